// ==== rtl/rops_output_select.sv ====
`timescale 1ns/1ps
// Functional notes
// - a nonzero 5-bit field below FUNC_COUNT routes the numbered peripheral output to its pin
// - second map register bits 4-0 select the function for pin 4
// - second map register bits 12-8 select the function for pin 5
// - third map register bits 4-0 select the function for pin 6
// - third map register bits 12-8 select the function for pin 7
// - fourth map register bits 4-0 select the function for pin 8
// - fourth map register bits 12-8 select the function for pin 9
// - fifth map register bits 4-0 select the function for pin 10
// - fifth map register bits 12-8 select the function for pin 11
// - sixth map register bits 12-8 select pin 13; no pin 12 field
// - unimplemented bits, and the sixth register's low byte, read zero
// - mapping bits are read/write and clear to zero at reset
module rops_output_select
  import rops_pkg::*;
#(
  parameter int FUNC_COUNT = FUNC_MAX
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [ADDR_W-1:0]     regAddr,
  input  wire logic [DATA_W-1:0]     regWrData,
  input  wire logic                  regWrEn,
  input  wire logic                  regRdEn,
  output logic      [DATA_W-1:0]     regRdData_reg,
  input  wire logic [FUNC_COUNT-1:0] periphOut,
  input  wire logic [PIN_COUNT-1:0]  portOut,
  output logic      [PIN_COUNT-1:0]  remapPinOut,
  output logic      [PIN_COUNT-1:0]  remapPinActive
);

  logic [SEL_W-1:0]     selReg   [PIN_COUNT];
  logic [SEL_W-1:0]     selNext  [PIN_COUNT];
  logic [PIN_COUNT-1:0] fieldWe;
  logic [SEL_W-1:0]     wrLo;
  logic [SEL_W-1:0]     wrHi;
  logic                 map2Hit;
  logic                 map3Hit;
  logic                 map4Hit;
  logic                 map5Hit;
  logic                 map6Hit;
  logic [DATA_W-1:0]    map2Word;
  logic [DATA_W-1:0]    map3Word;
  logic [DATA_W-1:0]    map4Word;
  logic [DATA_W-1:0]    map5Word;
  logic [DATA_W-1:0]    map6Word;
  logic [DATA_W-1:0]    rdWord;
  logic [DATA_W-1:0]    rdData_next;

  // address decode
  assign map2Hit = (regAddr == ADDR_MAP2);
  assign map3Hit = (regAddr == ADDR_MAP3);
  assign map4Hit = (regAddr == ADDR_MAP4);
  assign map5Hit = (regAddr == ADDR_MAP5);
  assign map6Hit = (regAddr == ADDR_MAP6);

  // only the field bits of the write word are taken
  assign wrLo = regWrData[FIELD_LO_LSB +: SEL_W];
  assign wrHi = regWrData[FIELD_HI_LSB +: SEL_W];

  assign fieldWe[PIN_4_IDX]  = regWrEn && map2Hit;
  assign fieldWe[PIN_5_IDX]  = regWrEn && map2Hit;
  assign fieldWe[PIN_6_IDX]  = regWrEn && map3Hit;
  assign fieldWe[PIN_7_IDX]  = regWrEn && map3Hit;
  assign fieldWe[PIN_8_IDX]  = regWrEn && map4Hit;
  assign fieldWe[PIN_9_IDX]  = regWrEn && map4Hit;
  assign fieldWe[PIN_10_IDX] = regWrEn && map5Hit;
  assign fieldWe[PIN_11_IDX] = regWrEn && map5Hit;
  // pin 13 high field, low byte unused
  assign fieldWe[PIN_13_IDX] = regWrEn && map6Hit;

  // next field values, low or high lane
  assign selNext[PIN_4_IDX]  = fieldWe[PIN_4_IDX]  ? wrLo
                                                   : selReg[PIN_4_IDX];
  assign selNext[PIN_5_IDX]  = fieldWe[PIN_5_IDX]  ? wrHi
                                                   : selReg[PIN_5_IDX];
  assign selNext[PIN_6_IDX]  = fieldWe[PIN_6_IDX]  ? wrLo
                                                   : selReg[PIN_6_IDX];
  assign selNext[PIN_7_IDX]  = fieldWe[PIN_7_IDX]  ? wrHi
                                                   : selReg[PIN_7_IDX];
  assign selNext[PIN_8_IDX]  = fieldWe[PIN_8_IDX]  ? wrLo
                                                   : selReg[PIN_8_IDX];
  assign selNext[PIN_9_IDX]  = fieldWe[PIN_9_IDX]  ? wrHi
                                                   : selReg[PIN_9_IDX];
  assign selNext[PIN_10_IDX] = fieldWe[PIN_10_IDX] ? wrLo
                                                   : selReg[PIN_10_IDX];
  assign selNext[PIN_11_IDX] = fieldWe[PIN_11_IDX] ? wrHi
                                                   : selReg[PIN_11_IDX];
  assign selNext[PIN_13_IDX] = fieldWe[PIN_13_IDX] ? wrHi
                                                   : selReg[PIN_13_IDX];

  // fields clear at reset, load on write
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < PIN_COUNT; i++) begin
      selReg[i] <= rst ? SEL_RESET : selNext[i];
    end
  end

  // read words with unimplemented bits at zero
  assign map2Word = {3'h0, selReg[PIN_5_IDX], 3'h0, selReg[PIN_4_IDX]};
  assign map3Word = {3'h0, selReg[PIN_7_IDX], 3'h0, selReg[PIN_6_IDX]};
  assign map4Word = {3'h0, selReg[PIN_9_IDX], 3'h0, selReg[PIN_8_IDX]};
  assign map5Word = {3'h0, selReg[PIN_11_IDX], 3'h0, selReg[PIN_10_IDX]};
  assign map6Word = {3'h0, selReg[PIN_13_IDX], 8'h00};

  // read select; unmapped offsets read zero
  always_comb begin
    if (map2Hit) begin
      rdWord = map2Word;
    end else if (map3Hit) begin
      rdWord = map3Word;
    end else if (map4Hit) begin
      rdWord = map4Word;
    end else if (map5Hit) begin
      rdWord = map5Word;
    end else if (map6Hit) begin
      rdWord = map6Word;
    end else begin
      rdWord = WORD_ZERO;
    end
  end

  assign rdData_next = regRdEn ? rdWord : WORD_ZERO;

  // read data valid only the cycle after the strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      regRdData_reg <= WORD_ZERO;
    end else begin
      regRdData_reg <= rdData_next;
    end
  end

  // one output stage per remappable pin
  for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
    rops_pin_mux #(
      .FUNC_COUNT (FUNC_COUNT)
    ) u_mux (
      .sys_clk         (sys_clk),
      .rst             (rst),
      .selCode         (selReg[p]),
      .periphOut       (periphOut),
      .portOut         (portOut[p]),
      .pinOut_reg      (remapPinOut[p]),
      .pinRemapped_reg (remapPinActive[p])
    );
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  a_reset_clear: assert property (
    $past(rst) |-> (selReg[PIN_4_IDX] == SEL_RESET &&
                    selReg[PIN_13_IDX] == SEL_RESET &&
                    selReg[PIN_8_IDX] == SEL_RESET))
    else $error("mapping field not cleared by reset");

  a_map2_low: assert property (
    (regWrEn && regAddr == ADDR_MAP2) |=>
      selReg[PIN_4_IDX] == $past(regWrData[4:0]))
    else $error("pin 4 field did not load bits 4-0");

  a_map2_high: assert property (
    (regWrEn && regAddr == ADDR_MAP2) |=>
      selReg[PIN_5_IDX] == $past(regWrData[12:8]))
    else $error("pin 5 field did not load bits 12-8");

  a_map3_low: assert property (
    (regWrEn && regAddr == ADDR_MAP3) |=>
      selReg[PIN_6_IDX] == $past(regWrData[4:0]))
    else $error("pin 6 field did not load bits 4-0");

  a_map3_high: assert property (
    (regWrEn && regAddr == ADDR_MAP3) |=>
      selReg[PIN_7_IDX] == $past(regWrData[12:8]))
    else $error("pin 7 field did not load bits 12-8");

  a_map4_fields: assert property (
    (regWrEn && regAddr == ADDR_MAP4) |=>
      (selReg[PIN_8_IDX] == $past(regWrData[4:0]) &&
       selReg[PIN_9_IDX] == $past(regWrData[12:8])))
    else $error("pin 8 or 9 field wrong after write");

  a_map5_fields: assert property (
    (regWrEn && regAddr == ADDR_MAP5) |=>
      (selReg[PIN_10_IDX] == $past(regWrData[4:0]) &&
       selReg[PIN_11_IDX] == $past(regWrData[12:8])))
    else $error("pin 10 or 11 field wrong after write");

  a_map6_field: assert property (
    (regWrEn && regAddr == ADDR_MAP6) |=>
      (selReg[PIN_13_IDX] == $past(regWrData[12:8]) &&
       $stable(selReg[PIN_11_IDX])))
    else $error("pin 13 field wrong or low byte leaked");

  a_zero_bits: assert property (
    regRdEn |=> (regRdData_reg[15:13] == 3'h0 &&
                 regRdData_reg[7:5] == 3'h0))
    else $error("unimplemented bits read nonzero");

  a_map6_lowbyte: assert property (
    (regRdEn && regAddr == ADDR_MAP6) |=> regRdData_reg[7:0] == 8'h00)
    else $error("sixth register low byte read nonzero");

  a_no_write_hold: assert property (
    !regWrEn |=> ($stable(selReg[PIN_4_IDX]) &&
                  $stable(selReg[PIN_7_IDX]) &&
                  $stable(selReg[PIN_13_IDX])))
    else $error("field changed without a write");

  sequence s_write_map3;
    regWrEn && regAddr == ADDR_MAP3;
  endsequence

  sequence s_read_map3;
    regRdEn && regAddr == ADDR_MAP3;
  endsequence

  a_readback: assert property (
    s_write_map3 ##1 s_read_map3 |=>
      regRdData_reg == ($past(regWrData, 2) & 16'h1F1F))
    else $error("read back differs from masked write");

  a_route_next: assert property (
    (regWrEn && regAddr == ADDR_MAP2 && regWrData[4:0] == 5'h00)
      |=> ##1 !remapPinActive[PIN_4_IDX])
    else $error("pin 4 not back on port two cycles after write");

  a_read_idle: assert property (
    !regRdEn |=> regRdData_reg == WORD_ZERO)
    else $error("read data present without read strobe");

endmodule

// ==== rtl/rops_pin_mux.sv ====
`timescale 1ns/1ps
module rops_pin_mux
  import rops_pkg::*;
#(
  parameter int FUNC_COUNT = FUNC_MAX
) (
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  input  wire logic [SEL_W-1:0]      selCode,
  input  wire logic [FUNC_COUNT-1:0] periphOut,
  input  wire logic                  portOut,
  output logic                       pinOut_reg,
  output logic                       pinRemapped_reg
);

  logic funcHit;
  logic pinOut_next;

  // zero or unknown number keeps port control
  assign funcHit = (selCode != SEL_PORT) &&
                   (int'(selCode) < FUNC_COUNT);
  assign pinOut_next = funcHit ? periphOut[selCode] : portOut;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pinOut_reg      <= 1'b0;
      pinRemapped_reg <= 1'b0;
    end else begin
      pinOut_reg      <= pinOut_next;
      pinRemapped_reg <= funcHit;
    end
  end

  a_route_function: assert property (@(posedge sys_clk) disable iff (rst)
    (selCode != SEL_PORT && int'(selCode) < FUNC_COUNT) |=>
      (pinRemapped_reg && pinOut_reg == $past(periphOut[selCode])))
    else $error("pin not driven by selected function");

  a_port_default: assert property (@(posedge sys_clk) disable iff (rst)
    (selCode == SEL_PORT) |=>
      (!pinRemapped_reg && pinOut_reg == $past(portOut)))
    else $error("zero selection did not restore port control");

endmodule

// ==== rtl/rops_pkg.sv ====
package rops_pkg;

  // bus and field geometry
  localparam int DATA_W    = 16;
  localparam int ADDR_W    = 3;
  localparam int SEL_W     = 5;
  localparam int PIN_COUNT = 9;
  localparam int FUNC_MAX  = 32;

  // register word offsets
  localparam logic [ADDR_W-1:0] ADDR_MAP2 = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_MAP3 = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_MAP4 = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_MAP5 = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_MAP6 = 3'h4;

  // field positions inside a register word
  localparam int FIELD_LO_LSB = 0;
  localparam int FIELD_HI_LSB = 8;

  // values after reset, and the port selection code
  localparam logic [SEL_W-1:0]  SEL_RESET  = 5'h00;
  localparam logic [DATA_W-1:0] WORD_ZERO  = 16'h0000;
  localparam logic [SEL_W-1:0]  SEL_PORT   = 5'h00;

  // slot of each remappable pin in the pin vectors
  localparam int PIN_4_IDX  = 0;
  localparam int PIN_5_IDX  = 1;
  localparam int PIN_6_IDX  = 2;
  localparam int PIN_7_IDX  = 3;
  localparam int PIN_8_IDX  = 4;
  localparam int PIN_9_IDX  = 5;
  localparam int PIN_10_IDX = 6;
  localparam int PIN_11_IDX = 7;
  localparam int PIN_13_IDX = 8;

endpackage

// ==== tb/rops_output_select_tb.sv ====
`timescale 1ns/1ps
module rops_output_select_tb import rops_pkg::*;;
  localparam int FC = 24;
  logic                 sys_clk;
  logic                 rst;
  logic                 regWrEn;
  logic                 regRdEn;
  logic [ADDR_W-1:0]    regAddr;
  logic [DATA_W-1:0]    regWrData;
  logic [DATA_W-1:0]    regRdData_reg;
  logic [FC-1:0]        periphOut;
  logic [PIN_COUNT-1:0] portOut;
  logic [PIN_COUNT-1:0] remapPinOut;
  logic [PIN_COUNT-1:0] remapPinActive;
  logic [SEL_W-1:0]     selModel [PIN_COUNT];
  int                   n_errors;
  int                   checked;
  int                   cyc;
  // rows: offset, word written, word read back
  logic [ADDR_W-1:0] rowAddr [9] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4,
                                     3'h5, 3'h4, 3'h3, 3'h0};
  logic [DATA_W-1:0] rowWr [9] = '{16'hFFE1, 16'hE9A5, 16'h0D11, 16'hF7F8,
    16'hFFFF, 16'hFFFF, 16'h0702, 16'h0003, 16'h1600};
  logic [DATA_W-1:0] rowRd [9] = '{16'h1F01, 16'h0905, 16'h0D11, 16'h1718,
    16'h1F00, 16'h0000, 16'h0700, 16'h0003, 16'h1600};

  rops_output_select #(.FUNC_COUNT(FC)) i_rops_output_select (
    .sys_clk        (sys_clk),
    .rst            (rst),
    .regAddr        (regAddr),
    .regWrData      (regWrData),
    .regWrEn        (regWrEn),
    .regRdEn        (regRdEn),
    .regRdData_reg  (regRdData_reg),
    .periphOut      (periphOut),
    .portOut        (portOut),
    .remapPinOut    (remapPinOut),
    .remapPinActive (remapPinActive)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic end_of_test;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 1000) begin
      n_errors++;
      end_of_test;
    end
  end

  task automatic chk(input string what, input logic [DATA_W-1:0] seen,
                     input logic [DATA_W-1:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    regWrEn <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    regRdEn <= 1'b1;
    regAddr <= a;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    #1 chk("read data", regRdData_reg, e);
    @(posedge sys_clk);
    #1 chk("read idle", regRdData_reg, WORD_ZERO);
    @(posedge sys_clk);
  endtask

  task automatic pins(input logic [FC-1:0] p, input logic [PIN_COUNT-1:0] q);
    logic [PIN_COUNT-1:0] eo;
    logic [PIN_COUNT-1:0] ea;
    periphOut <= p;
    portOut <= q;
    repeat (2) @(posedge sys_clk);
    #1;
    for (int j = 0; j < PIN_COUNT; j++) begin
      ea[j] = selModel[j] != SEL_PORT && selModel[j] < FC;
      eo[j] = ea[j] ? periphOut[selModel[j]] : portOut[j];
    end
    chk("pin drive", 16'(remapPinOut), 16'(eo));
    chk("pin active", 16'(remapPinActive), 16'(ea));
    @(posedge sys_clk);
  endtask

  initial begin
    rst = 1'b1;
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = '0;
    regWrData = '0;
    periphOut = '1;
    portOut = 9'h155;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    foreach (selModel[j]) selModel[j] = SEL_RESET;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    for (int a = 0; a < 5; a++) rd(a[ADDR_W-1:0], WORD_ZERO);
    pins(24'h5A5A5A, 9'h0F3);
    for (int i = 0; i < 9; i++) begin
      wr(rowAddr[i], rowWr[i]);
      rd(rowAddr[i], rowRd[i]);
      if (rowAddr[i] < ADDR_MAP6) begin
        selModel[2*rowAddr[i]] = rowRd[i][FIELD_LO_LSB +: SEL_W];
        selModel[2*rowAddr[i]+1] = rowRd[i][FIELD_HI_LSB +: SEL_W];
      end else if (rowAddr[i] == ADDR_MAP6) begin
        selModel[PIN_13_IDX] = rowRd[i][FIELD_HI_LSB +: SEL_W];
      end
      pins(24'hC3A50F, 9'h1A6);
      pins(~24'hC3A50F, 9'h059);
    end
    // pin 4 moves from port control to function 20
    periphOut <= 24'h100000;
    portOut <= 9'h000;
    wr(ADDR_MAP2, 16'h1614);
    #1 chk("pin4 old", 16'(remapPinOut[PIN_4_IDX]), 16'h0000);
    chk("pin4 old act", 16'(remapPinActive[PIN_4_IDX]), 16'h0000);
    @(posedge sys_clk);
    #1 chk("pin4 new", 16'(remapPinOut[PIN_4_IDX]), 16'h0001);
    chk("pin4 new act", 16'(remapPinActive[PIN_4_IDX]), 16'h0001);
    // second reset in mid-run
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    foreach (selModel[j]) selModel[j] = SEL_RESET;
    @(posedge sys_clk);
    for (int a = 0; a < 5; a++) rd(a[ADDR_W-1:0], WORD_ZERO);
    pins(24'hFFFFFF, 9'h0C5);
    end_of_test;
  end
endmodule
